// ---- rtl/pcg_pkg.sv ----
// ==========================================================================
// Peripheral clock gating: shared constants and types
// ==========================================================================
package pcg_pkg;

    // ======================================================================
    // Bus geometry
    // ======================================================================
    localparam int ADDR_W = 12;                     // Byte address width
    localparam int DATA_W = 32;                     // Register data width

    // ======================================================================
    // Register byte offsets
    // ======================================================================
    localparam logic [ADDR_W-1:0] OFF_RUN0   = 12'h100; // run_gate_set_zero
    localparam logic [ADDR_W-1:0] OFF_RUN1   = 12'h104; // run_gate_set_one
    localparam logic [ADDR_W-1:0] OFF_SLEEP0 = 12'h110; // sleep_gate_set_zero
    localparam logic [ADDR_W-1:0] OFF_SLEEP1 = 12'h114; // sleep_gate_set_one
    localparam logic [ADDR_W-1:0] OFF_DEEP0  = 12'h120; // deep_sleep_gate_set_zero
    localparam logic [ADDR_W-1:0] OFF_CFG    = 12'h060; // run_clock_config
    localparam logic [ADDR_W-1:0] OFF_STAT   = 12'h130; // Gating status, read only

    // ======================================================================
    // Writable field masks and reset values
    // ======================================================================
    localparam logic [DATA_W-1:0] MASK_SET0 = 32'h0100_0048; // Bits 24, 6, 3
    localparam logic [DATA_W-1:0] MASK_SET1 = 32'h030f_5037; // Timers, serial, comparators
    localparam logic [DATA_W-1:0] MASK_CFG  = 32'h0800_0000; // Auto gating select only
    localparam int                ACG_BIT   = 27;            // auto_gating_select position
    localparam logic [DATA_W-1:0] RST_GATE  = 32'h0000_0000; // All units unclocked
    localparam logic [DATA_W-1:0] RST_CFG   = 32'h0000_0000; // Auto gating off
    localparam int                STAT_MODE_LSB = 0;         // Status bits 1:0 hold mode

    // ======================================================================
    // Register index and power mode
    // ======================================================================
    typedef enum logic [2:0] {
        REG_RUN0, REG_SLEEP0, REG_DEEP0, REG_RUN1, REG_SLEEP1, REG_CFG, REG_STAT, REG_NONE
    } pcg_reg_e;
    localparam int NUM_RW = 6;                      // Stored registers

    typedef enum logic [1:0] {
        MODE_RUN, MODE_SLEEP, MODE_DEEP
    } pcg_mode_e;

    localparam logic [DATA_W-1:0] REG_MASK [NUM_RW] = '{
        MASK_SET0, MASK_SET0, MASK_SET0, MASK_SET1, MASK_SET1, MASK_CFG
    };
    localparam logic [DATA_W-1:0] REG_RST [NUM_RW] = '{
        RST_GATE, RST_GATE, RST_GATE, RST_GATE, RST_GATE, RST_CFG
    };

    // ======================================================================
    // Gated units: index, bit position, and which register set holds it
    // ======================================================================
    localparam int NUM_UNITS = 16;
    localparam int UNIT_ID_W = 4;
    // 0 can, 1 hib, 2 wdt, 3-6 timers a-d, 7-8 two-wire a-b,
    // 9-10 sync serial a-b, 11-13 async serial a-c, 14-15 comparators a-b
    localparam int UNIT_BIT [NUM_UNITS] = '{
        24, 6, 3, 16, 17, 18, 19, 12, 14, 4, 5, 0, 1, 2, 24, 25
    };
    localparam bit UNIT_IN_SET1 [NUM_UNITS] = '{
        1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1
    };

endpackage

// ---- rtl/pcg_reg_if.sv ----
`timescale 1ns/10ps
// ==========================================================================
// Carrier between bus front end and register store
// ==========================================================================
interface pcg_reg_if;
    logic                           wr;             // Write strobe
    logic                           rd;             // Read strobe
    pcg_pkg::pcg_reg_e              idx;            // Decoded register
    logic [pcg_pkg::DATA_W-1:0]     wdata;          // Write data
    logic [pcg_pkg::DATA_W-1:0]     status;         // Live status word
    logic [pcg_pkg::DATA_W-1:0]     rdata;          // Registered read data
    logic [pcg_pkg::DATA_W-1:0]     regs [pcg_pkg::NUM_RW]; // Stored values

    modport store (input wr, rd, idx, wdata, status, output rdata, regs);
    modport ctl   (output wr, rd, idx, wdata, status, input rdata, regs);
endinterface

// ---- rtl/pcg_regfile.sv ----
`timescale 1ns/10ps
// ==========================================================================
// Gating register store with registered read port
// ==========================================================================
module pcg_regfile (
    input  wire logic  sys_clk,                     // System clock
    input  wire logic  srst,                        // Sync reset, high
    input  wire logic  clk_en,                      // Freezes all state when low
    pcg_reg_if.store   rf                           // Bus side carrier
);

    // ======================================================================
    // Stored registers
    // ======================================================================
    logic [pcg_pkg::DATA_W-1:0] regs_ff     [pcg_pkg::NUM_RW]; // Current values
    logic [pcg_pkg::DATA_W-1:0] nxt_regs    [pcg_pkg::NUM_RW]; // Next values
    logic [pcg_pkg::DATA_W-1:0] rdata_ff;                      // Read data
    logic [pcg_pkg::DATA_W-1:0] nxt_rdata;                     // Next read data

    genvar g;
    generate
        for (g = 0; g < pcg_pkg::NUM_RW; g++) begin : g_reg
            // Reserved positions are masked on write so they never store
            always_comb begin
                nxt_regs[g] = regs_ff[g];
                if (rf.wr && (rf.idx == pcg_pkg::pcg_reg_e'(g))) begin
                    nxt_regs[g] = rf.wdata & pcg_pkg::REG_MASK[g];
                end
            end

            // Reset clears every gating bit so all units start unclocked
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    regs_ff[g] <= pcg_pkg::REG_RST[g];
                end else if (clk_en) begin
                    regs_ff[g] <= nxt_regs[g];
                end
            end
            assign rf.regs[g] = regs_ff[g];
        end
    endgenerate

    // ======================================================================
    // Read port: data stand only in the cycle after the strobe
    // ======================================================================
    always_comb begin
        nxt_rdata = '0;
        if (rf.rd) begin
            if (rf.idx == pcg_pkg::REG_STAT) begin
                nxt_rdata = rf.status;
            end else if (rf.idx < pcg_pkg::REG_STAT) begin
                nxt_rdata = regs_ff[rf.idx];         // Reserved bits already zero
            end
        end
    end

    // Read data register; unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_ff <= '0;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign rf.rdata = rdata_ff;

    // ======================================================================
    // Checks
    // ======================================================================
    property p_rsv_zero;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && rf.rd && (rf.idx == pcg_pkg::REG_RUN1))
            |=> ((rf.rdata & ~pcg_pkg::MASK_SET1) == '0);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bit read as one");

    property p_wr_store;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && rf.wr && (rf.idx == pcg_pkg::REG_SLEEP1))
            |=> (regs_ff[4] == ($past(rf.wdata) & pcg_pkg::MASK_SET1));
    endproperty
    a_wr_store: assert property (p_wr_store) else $error("Gating write not stored");

endmodule

// ---- rtl/pcg_clock_gating.sv ----
`timescale 1ns/10ps
// Functional notes
// - Set bit clocks unit, clear bit stops it
// - Access to unclocked unit raises bus fault
// - All gating bits clear on reset
// - Run, sleep, deep copies follow processor state
// - Sleep copies apply only with auto gating
// - Set one bits 16-19 gate timers
// - Set one bits 12, 14 gate two-wire units
// - Set one bits 4, 5 gate sync serial
// - Set one bits 0-2 gate async serial
module pcg_clock_gating (
    input  wire logic                           sys_clk,        // System clock, 250 MHz
    input  wire logic                           srst,           // Sync reset, high
    input  wire logic                           clk_en,         // Freezes all state when low
    input  wire logic [pcg_pkg::ADDR_W-1:0]     reg_addr,       // Register byte address
    input  wire logic [pcg_pkg::DATA_W-1:0]     reg_wdata,      // Register write data
    input  wire logic                           reg_wr,         // Write strobe
    input  wire logic                           reg_rd,         // Read strobe
    output logic      [pcg_pkg::DATA_W-1:0]     reg_rdata,      // Read data, cycle after strobe
    input  wire logic                           cpu_sleep,      // Processor in sleep
    input  wire logic                           cpu_deep_sleep, // Processor in deep sleep
    input  wire logic                           periph_acc,     // Bus access to a unit
    input  wire logic [pcg_pkg::UNIT_ID_W-1:0]  periph_id,      // Unit addressed
    output logic      [pcg_pkg::NUM_UNITS-1:0]  unit_clk_en,    // Per-unit clock enables
    output logic                                bus_fault       // Fault answer, one cycle
);

    // ======================================================================
    // Address decode
    // ======================================================================
    // Maps a byte address to a register; anything else is unmapped
    function automatic pcg_pkg::pcg_reg_e reg_index(input logic [pcg_pkg::ADDR_W-1:0] a);
        case (a)
            pcg_pkg::OFF_RUN0:   reg_index = pcg_pkg::REG_RUN0;
            pcg_pkg::OFF_SLEEP0: reg_index = pcg_pkg::REG_SLEEP0;
            pcg_pkg::OFF_DEEP0:  reg_index = pcg_pkg::REG_DEEP0;
            pcg_pkg::OFF_RUN1:   reg_index = pcg_pkg::REG_RUN1;
            pcg_pkg::OFF_SLEEP1: reg_index = pcg_pkg::REG_SLEEP1;
            pcg_pkg::OFF_CFG:    reg_index = pcg_pkg::REG_CFG;
            pcg_pkg::OFF_STAT:   reg_index = pcg_pkg::REG_STAT;
            default:             reg_index = pcg_pkg::REG_NONE;
        endcase
    endfunction

    // Picks one unit's enable bit from the selected set-zero or set-one word
    function automatic logic unit_bit(input logic [pcg_pkg::DATA_W-1:0] s0,
                                      input logic [pcg_pkg::DATA_W-1:0] s1,
                                      input int                         u);
        unit_bit = pcg_pkg::UNIT_IN_SET1[u] ? s1[pcg_pkg::UNIT_BIT[u]] : s0[pcg_pkg::UNIT_BIT[u]];
    endfunction

    // ======================================================================
    // Register store
    // ======================================================================
    pcg_reg_if rf ();                               // Carrier to store

    pcg_pkg::pcg_mode_e             mode_ff;        // Applied power mode
    pcg_pkg::pcg_mode_e             nxt_mode;       // Next power mode
    logic [pcg_pkg::NUM_UNITS-1:0]  gate_ff;        // Registered unit enables
    logic [pcg_pkg::NUM_UNITS-1:0]  nxt_gate;       // Next unit enables
    logic                           fault_ff;       // Registered fault answer
    logic                           nxt_fault;      // Next fault answer
    logic [pcg_pkg::DATA_W-1:0]     sel0;           // Set-zero copy in force
    logic [pcg_pkg::DATA_W-1:0]     sel1;           // Set-one copy in force
    logic                           auto_gating_select;            // Auto gating select

    // Strobes are forwarded untouched; the store adds the read register stage
    assign rf.wr    = reg_wr;
    assign rf.rd    = reg_rd;
    assign rf.idx   = reg_index(reg_addr);
    assign rf.wdata = reg_wdata;
    assign rf.status = {{(pcg_pkg::DATA_W-2){1'b0}}, mode_ff} << pcg_pkg::STAT_MODE_LSB;
    assign reg_rdata = rf.rdata;

    pcg_regfile u_store (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clk_en  (clk_en),
        .rf      (rf.store)
    );

    assign auto_gating_select = rf.regs[pcg_pkg::REG_CFG][pcg_pkg::ACG_BIT];

    // ======================================================================
    // Power mode tracking
    // ======================================================================
    // Without auto gating the run copy governs whatever the processor does
    always_comb begin
        nxt_mode = pcg_pkg::MODE_RUN;
        if (auto_gating_select) begin
            if (cpu_deep_sleep) begin
                nxt_mode = pcg_pkg::MODE_DEEP;
            end else if (cpu_sleep) begin
                nxt_mode = pcg_pkg::MODE_SLEEP;
            end
        end
    end

    // Mode register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_ff <= pcg_pkg::MODE_RUN;
        end else if (clk_en) begin
            mode_ff <= nxt_mode;
        end
    end

    // ======================================================================
    // Copy selection and per-unit enables
    // ======================================================================
    // Deep sleep has no set-one copy here, so the sleep set-one copy stands in
    always_comb begin
        case (mode_ff)
            pcg_pkg::MODE_RUN: begin
                sel0 = rf.regs[pcg_pkg::REG_RUN0];
                sel1 = rf.regs[pcg_pkg::REG_RUN1];
            end
            pcg_pkg::MODE_SLEEP: begin
                sel0 = rf.regs[pcg_pkg::REG_SLEEP0];
                sel1 = rf.regs[pcg_pkg::REG_SLEEP1];
            end
            pcg_pkg::MODE_DEEP: begin
                sel0 = rf.regs[pcg_pkg::REG_DEEP0];
                sel1 = rf.regs[pcg_pkg::REG_SLEEP1];
            end
            default: begin                           // Unused code: fall back to run
                sel0 = rf.regs[pcg_pkg::REG_RUN0];
                sel1 = rf.regs[pcg_pkg::REG_RUN1];
            end
        endcase
    end

    // One enable per unit, taken from its documented bit position
    genvar u;
    generate
        for (u = 0; u < pcg_pkg::NUM_UNITS; u++) begin : g_unit
            assign nxt_gate[u] = unit_bit(sel0, sel1, u);
        end
    endgenerate

    // ======================================================================
    // Bus fault for accesses to unclocked units
    // ======================================================================
    // Judged against the enable the unit really has this cycle
    always_comb begin
        nxt_fault = periph_acc && !gate_ff[periph_id];
    end

    // Enable and fault registers; reset leaves every unit unclocked
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gate_ff  <= '0;
            fault_ff <= 1'b0;
        end else if (clk_en) begin
            gate_ff  <= nxt_gate;
            fault_ff <= nxt_fault;
        end
    end

    assign unit_clk_en = gate_ff;
    assign bus_fault   = fault_ff;

    // ======================================================================
    // Checks
    // ======================================================================
    property p_reset_clear;
        @(posedge sys_clk)
        srst |=> (unit_clk_en == '0) && (mode_ff == pcg_pkg::MODE_RUN);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Enables not clear after reset");

    property p_auto_off;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && !auto_gating_select) |=> (mode_ff == pcg_pkg::MODE_RUN);
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("Sleep copy used without auto gating");

    property p_deep_sel;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && auto_gating_select && cpu_deep_sleep) |=> (mode_ff == pcg_pkg::MODE_DEEP);
    endproperty
    a_deep_sel: assert property (p_deep_sel) else $error("Deep sleep copy not selected");

    property p_timer_run;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && mode_ff == pcg_pkg::MODE_RUN)
            |=> (unit_clk_en[6:3] == $past(rf.regs[pcg_pkg::REG_RUN1][19:16]));
    endproperty
    a_timer_run: assert property (p_timer_run) else $error("Timer enable mismatch");

    property p_twowire_sleep;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && mode_ff == pcg_pkg::MODE_SLEEP)
            |=> (unit_clk_en[8:7] == {$past(rf.regs[pcg_pkg::REG_SLEEP1][14]),
                                      $past(rf.regs[pcg_pkg::REG_SLEEP1][12])});
    endproperty
    a_twowire_sleep: assert property (p_twowire_sleep) else $error("Two-wire enable mismatch");

    property p_sync_serial;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && mode_ff == pcg_pkg::MODE_RUN)
            |=> (unit_clk_en[10:9] == $past(rf.regs[pcg_pkg::REG_RUN1][5:4]));
    endproperty
    a_sync_serial: assert property (p_sync_serial) else $error("Sync serial enable mismatch");

    property p_async_serial;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && mode_ff == pcg_pkg::MODE_RUN)
            |=> (unit_clk_en[13:11] == $past(rf.regs[pcg_pkg::REG_RUN1][2:0]));
    endproperty
    a_async_serial: assert property (p_async_serial) else $error("Async serial enable mismatch");

    property p_set0_deep;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && mode_ff == pcg_pkg::MODE_DEEP)
            |=> (unit_clk_en[2:0] == {$past(rf.regs[pcg_pkg::REG_DEEP0][3]),
                                      $past(rf.regs[pcg_pkg::REG_DEEP0][6]),
                                      $past(rf.regs[pcg_pkg::REG_DEEP0][24])});
    endproperty
    a_set0_deep: assert property (p_set0_deep) else $error("Set zero enable mismatch");

    property p_fault;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && periph_acc && !unit_clk_en[periph_id]) |=> bus_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("Missing bus fault");

    property p_no_fault;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && !(periph_acc && !unit_clk_en[periph_id])) |=> !bus_fault;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("Fault on clocked unit");

    c_fault: cover property (@(posedge sys_clk) disable iff (srst) bus_fault);
    c_sleep: cover property (@(posedge sys_clk) disable iff (srst) mode_ff == pcg_pkg::MODE_SLEEP);
    c_deep:  cover property (@(posedge sys_clk) disable iff (srst)
                             mode_ff == pcg_pkg::MODE_DEEP && unit_clk_en != '0);

endmodule

// ---- dv/pcg_clock_gating_test.sv ----
`timescale 1ns/10ps
module pcg_clock_gating_test;
    // ======================================================================
    // Stimulus, observation and scoreboard state
    // ======================================================================
    logic                          sys_clk, srst, clk_en;                 // Clock, reset, enable
    logic                          reg_wr, reg_rd, periph_acc, bus_fault; // Strobes and fault answer
    logic                          cpu_sleep, cpu_deep_sleep;             // Processor power state
    logic [pcg_pkg::ADDR_W-1:0]    reg_addr;                              // Register byte address
    logic [pcg_pkg::DATA_W-1:0]    reg_wdata, reg_rdata;                  // Register data
    logic [pcg_pkg::UNIT_ID_W-1:0] periph_id;                             // Unit addressed
    logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_en;                           // Per-unit enables
    logic [pcg_pkg::DATA_W-1:0]    sh [logic [pcg_pkg::ADDR_W-1:0]];      // Shadow of stored registers
    logic [pcg_pkg::DATA_W-1:0]    rd_q [$];                              // Expected read data
    logic                          flt_q [$];                             // Expected fault answers
    logic                          rd_d, acc_d;                           // Strobe taken at last edge
    int                            num_errors, num_checks, seed_ret;      // Counters
    // Every register, the status word and one unmapped hole
    localparam logic [pcg_pkg::ADDR_W-1:0] ADDRS [8] = '{pcg_pkg::OFF_RUN0, pcg_pkg::OFF_RUN1,
        pcg_pkg::OFF_SLEEP0, pcg_pkg::OFF_SLEEP1, pcg_pkg::OFF_DEEP0, pcg_pkg::OFF_CFG, pcg_pkg::OFF_STAT, 12'h0fc};

    pcg_clock_gating u_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep),
        .cpu_deep_sleep(cpu_deep_sleep), .periph_acc(periph_acc), .periph_id(periph_id),
        .unit_clk_en(unit_clk_en), .bus_fault(bus_fault));

    // ======================================================================
    // Reference model built from the register map
    // ======================================================================
    function automatic logic [31:0] mask_of(input logic [11:0] a);
        case (a)
            pcg_pkg::OFF_RUN0, pcg_pkg::OFF_SLEEP0, pcg_pkg::OFF_DEEP0: return pcg_pkg::MASK_SET0;
            pcg_pkg::OFF_RUN1, pcg_pkg::OFF_SLEEP1: return pcg_pkg::MASK_SET1;
            pcg_pkg::OFF_CFG: return pcg_pkg::MASK_CFG;
            default: return 32'h0000_0000; // Status and holes store nothing
        endcase
    endfunction

    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        // Status shows run unless auto gating is on; deep sleep wins over sleep
        if (a == pcg_pkg::OFF_STAT) return sh[pcg_pkg::OFF_CFG][pcg_pkg::ACG_BIT] ?
            {30'h0000_0000, cpu_deep_sleep, cpu_sleep & ~cpu_deep_sleep} : 32'h0000_0000;
        return (mask_of(a) != 32'h0000_0000) ? sh[a] : 32'h0000_0000;
    endfunction

    function automatic logic [15:0] exp_en();
        logic [31:0] a;
        logic [31:0] b;
        logic [15:0] e;
        logic        auto_gating_select;
        auto_gating_select = sh[pcg_pkg::OFF_CFG][pcg_pkg::ACG_BIT];
        a = sh[pcg_pkg::OFF_RUN0];
        b = sh[pcg_pkg::OFF_RUN1];
        // Without auto gating the run copies govern in every state
        if (auto_gating_select && (cpu_sleep || cpu_deep_sleep)) b = sh[pcg_pkg::OFF_SLEEP1];
        if (auto_gating_select && cpu_sleep && !cpu_deep_sleep) a = sh[pcg_pkg::OFF_SLEEP0];
        if (auto_gating_select && cpu_deep_sleep) a = sh[pcg_pkg::OFF_DEEP0];
        for (int u = 0; u < 16; u++) e[u] = pcg_pkg::UNIT_IN_SET1[u] ? b[pcg_pkg::UNIT_BIT[u]] : a[pcg_pkg::UNIT_BIT[u]];
        return e;
    endfunction

    // ======================================================================
    // Bus driver tasks; each sets every strobe once per edge
    // ======================================================================
    task automatic step(input logic w, input logic r, input logic a);
        @(posedge sys_clk);
        reg_wr     <= w;
        reg_rd     <= r;
        periph_acc <= a;
        clk_en     <= 1'b1;
    endtask

    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b0, 1'b0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        step(1'b1, 1'b0, 1'b0);
        reg_addr  <= a;
        reg_wdata <= d;
        if (mask_of(a) != 32'h0000_0000) sh[a] = d & mask_of(a);
    endtask

    task automatic rd(input logic [11:0] a);
        step(1'b0, 1'b1, 1'b0);
        reg_addr <= a;
        rd_q.push_back(exp_rd(a));
    endtask

    task automatic acc(input int id);
        logic [15:0] e;
        e = exp_en();
        step(1'b0, 1'b0, 1'b1);
        periph_id <= 4'(id);
        flt_q.push_back(~e[id]);
    endtask

    task automatic mode(input logic s, input logic d);
        step(1'b0, 1'b0, 1'b0);
        cpu_sleep      <= s;
        cpu_deep_sleep <= d;
        idle(3); // Enables follow two cycles after a state change
    endtask

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_flag(input string what, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ======================================================================
    // Monitor: answers are one cycle after the strobe, judged mid-cycle
    // ======================================================================
    always @(posedge sys_clk) begin
        rd_d  <= reg_rd & clk_en;
        acc_d <= periph_acc & clk_en;
    end

    always @(negedge sys_clk) begin
        if (rd_d === 1'b1) chk_word("reg_rdata", rd_q.pop_front(), reg_rdata);
        if (acc_d === 1'b1) chk_flag("bus_fault", flt_q.pop_front(), bus_fault);
        else if (srst === 1'b0) chk_flag("bus_fault idle", 1'b0, bus_fault);
    end

    // ======================================================================
    // Clock, watchdog and main sequence
    // ======================================================================
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        {srst, clk_en, reg_wr, reg_rd, periph_acc, cpu_sleep, cpu_deep_sleep} = 7'h41;
        {reg_addr, reg_wdata, periph_id} = '0;
        num_errors = 0;
        num_checks = 0;
        seed_ret = $urandom(75587);
        foreach (ADDRS[i]) if (mask_of(ADDRS[i]) != 32'h0000_0000) sh[ADDRS[i]] = 32'h0000_0000;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (ADDRS[i]) rd(ADDRS[i]);
        idle(2);
        chk_word("unit_clk_en", 32'h0000_0000, {16'h0000, unit_clk_en});
        // Each unit alone: its bit position, then no fault on it and a fault on its neighbour
        // Reserved bits are written as zero, which is also what they read
        for (int u = 0; u < 16; u++) begin
            wr(pcg_pkg::OFF_RUN0, pcg_pkg::UNIT_IN_SET1[u] ? 32'h0 : (32'h1 << pcg_pkg::UNIT_BIT[u]));
            wr(pcg_pkg::OFF_RUN1, pcg_pkg::UNIT_IN_SET1[u] ? (32'h1 << pcg_pkg::UNIT_BIT[u]) : 32'h0);
            idle(3);
            chk_word("unit_clk_en", 32'h1 << u, {16'h0000, unit_clk_en});
            acc(u);
            acc((u + 1) % 16);
        end
        // Random contents in every copy, with auto gating off then on
        for (int k = 0; k < 4; k++) begin
            foreach (ADDRS[i]) wr(ADDRS[i], $urandom);
            wr(pcg_pkg::OFF_CFG, ($urandom & ~pcg_pkg::MASK_CFG) | (k[0] ? pcg_pkg::MASK_CFG : 32'h0));
            foreach (ADDRS[i]) rd(ADDRS[i]);
            for (int m = 0; m < 4; m++) begin
                mode(m[0], m[1]);
                chk_word("unit_clk_en", {16'h0000, exp_en()}, {16'h0000, unit_clk_en});
                if (k[0]) rd(pcg_pkg::OFF_STAT);
                for (int u = 0; u < 16; u++) acc(u);
            end
            mode(1'b0, 1'b0);
        end
        // A write while the enable is low must not be taken
        @(posedge sys_clk);
        reg_addr  <= pcg_pkg::OFF_RUN1;
        reg_wdata <= ~sh[pcg_pkg::OFF_RUN1];
        reg_wr    <= 1'b1;
        clk_en    <= 1'b0;
        idle(2);
        rd(pcg_pkg::OFF_RUN1);
        idle(2);
        // Second reset in mid-run clears every copy
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        foreach (ADDRS[i]) if (mask_of(ADDRS[i]) != 32'h0000_0000) sh[ADDRS[i]] = 32'h0000_0000;
        foreach (ADDRS[i]) rd(ADDRS[i]);
        idle(3);
        chk_word("unit_clk_en", 32'h0000_0000, {16'h0000, unit_clk_en});
        end_of_test();
    end
endmodule
